// ===== src/tref_defs.vh
// register map, field layout, reset values and counts of the timing reference control
`ifndef TREF_DEFS_VH
`define TREF_DEFS_VH

// byte addresses on the apb bus
`define TREF_CTRL_ADDR      8'h40
`define TREF_RATE_ADDR      8'h44
`define TREF_STATUS_ADDR    8'h48

// control register fields
`define TREF_SRC_MSB        7
`define TREF_SRC_LSB        6
`define TREF_MRST_BIT       5
`define TREF_RSVD_BIT       4
`define TREF_LOOP_MSB       3
`define TREF_LOOP_LSB       0

// reset values
`define TREF_SRC_RST        2'h0
`define TREF_LOOP_RST       4'h0
`define TREF_RATE_RST       8'h00

// line clock multiplier codes
`define TREF_MULT_1X        2'h0
`define TREF_MULT_2X        2'h1
`define TREF_MULT_4X        2'h2

// receive reference pulse widths in clock cycles
`define TREF_WIDTH_PLAIN    4'h1
`define TREF_WIDTH_1X       4'h2
`define TREF_WIDTH_2X       4'h4
`define TREF_WIDTH_4X       4'h8

// master reset pulse length in clock cycles
`define TREF_MRST_CYCLES    4'h8

// edges the pin synchroniser needs before its edges count
`define TREF_SYNC_FILL      2'h3

`endif

// ===== src/pulse_widen.v
// one-port pulse stretcher for the received timing marker
`timescale 1ns/1ps

module pulse_widen (
  input  wire       clk,
  input  wire       clr,
  input  wire       trig,
  input  wire [3:0] width,
  output wire       pulse
);

  reg [3:0] count_q;
  reg [3:0] count_d;

  always @* begin
    count_d = count_q;
    if (trig) begin
      count_d = width;
    end else if (count_q != 4'h0) begin
      count_d = count_q - 4'h1;
    end
  end

  always @(posedge clk) begin
    if (clr) begin
      count_q <= 4'h0;
    end else begin
      count_q <= count_d;
    end
  end

  assign pulse = (count_q != 4'h0);

endmodule

// ===== src/timing_reference_control.v
// global timing reference control: source select, marker loop-back and master reset
//
// What this block does
// - two-bit field picks receive reference port, default 0
// - writing one to bit 5 resets; self-clearing
// - loop bit zero: markers from external reference
// - loop bit one: received markers looped to transmit
// - looped: widen reference pulse 2x/4x/8x per multiplier
// - per-port two-bit line rate sets clock multiplier
`timescale 1ns/1ps
`include "tref_defs.vh"

module timing_reference_control (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire [3:0]  PORT_RX_MARKER,
  input  wire        TX_TIMING_REF_IN,
  output wire        RX_TIMING_REF_OUT,
  output wire [3:0]  TX_MARKER_REQ,
  output wire [7:0]  LINE_RATE,
  output wire        MASTER_RESET
);

  // apb slave state
  localparam BUS_IDLE   = 1'b0;
  localparam BUS_ACCESS = 1'b1;

  reg        bus_state_q;
  reg        bus_state_d;
  reg        ready_q;
  reg        slverr_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  reg        hit_d;

  // software-visible fields, plus src_live_q, the internal live copy of the source select
  reg [1:0]  src_sel_q;
  reg [1:0]  src_live_q;
  reg [3:0]  loop_sel_q;
  reg [7:0]  line_rate_q;

  // master reset sequencing
  reg [3:0]  mrst_count_q;
  reg [3:0]  mrst_count_d;
  reg        mrst_out_q;

  // external transmit reference: two-stage synchroniser then edge detect
  reg        tx_timing_ref_in_meta_q;
  reg        tx_timing_ref_in_sync_q;
  reg        tx_timing_ref_in_prev_q;
  reg [1:0]  tx_timing_ref_in_fill_q;
  wire       tx_timing_ref_in_rise;

  // outputs toward the port paths
  reg [3:0]  tx_marker_q;
  reg [3:0]  tx_marker_d;
  reg        rx_ref_out_q;
  reg [3:0]  width_d [0:3];
  wire [3:0] widened;

  wire       setup_phase;
  wire       access_done;
  wire       wr_ctrl;
  wire       wr_rate;
  wire       mrst_req;
  wire       mrst_busy;
  wire       block_clr;

  integer    i;

  assign setup_phase = PSEL & ~PENABLE;
  assign access_done = PSEL & PENABLE & ready_q;
  assign wr_ctrl     = access_done & PWRITE & ~slverr_q & (PADDR == `TREF_CTRL_ADDR);
  assign wr_rate     = access_done & PWRITE & ~slverr_q & (PADDR == `TREF_RATE_ADDR);

  assign mrst_req    = wr_ctrl & PWDATA[`TREF_MRST_BIT];
  assign mrst_busy   = (mrst_count_q != 4'h0);
  // the reset write silences the outputs from its own edge onward
  assign block_clr   = ~RST_N | mrst_req | mrst_busy;

  // read mux and address decode, evaluated in the setup phase
  always @* begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    case (PADDR)
      `TREF_CTRL_ADDR: begin
        // reserved and write-only bits read as zero
        rdata_d[`TREF_SRC_MSB:`TREF_SRC_LSB]   = src_sel_q;
        rdata_d[`TREF_LOOP_MSB:`TREF_LOOP_LSB] = loop_sel_q;
      end
      `TREF_RATE_ADDR: begin
        rdata_d[7:0] = line_rate_q;
      end
      `TREF_STATUS_ADDR: begin
        rdata_d[0]   = mrst_busy;
        rdata_d[1]   = tx_timing_ref_in_sync_q;
        rdata_d[2]   = rx_ref_out_q;
        rdata_d[7:4] = widened;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // every setup cycle earns one wait-free access cycle, then the bus idles
  always @* begin
    bus_state_d = BUS_IDLE;
    case (bus_state_q)
      BUS_IDLE: begin
        if (setup_phase) begin
          bus_state_d = BUS_ACCESS;
        end
      end
      BUS_ACCESS: begin
        if (setup_phase) begin
          bus_state_d = BUS_ACCESS;
        end
      end
      default: begin
        bus_state_d = BUS_IDLE;
      end
    endcase
  end

  // single-cycle access phase: ready is raised by the setup cycle
  always @(posedge CLK) begin
    if (!RST_N) begin
      bus_state_q <= BUS_IDLE;
      ready_q  <= 1'b0;
      slverr_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end else begin
      bus_state_q <= bus_state_d;
      ready_q  <= (bus_state_d == BUS_ACCESS);
      if (setup_phase) begin
        slverr_q <= ~hit_d;
        rdata_q  <= PWRITE ? 32'h0000_0000 : rdata_d;
      end else if (access_done) begin
        slverr_q <= 1'b0;
        rdata_q  <= 32'h0000_0000;
      end
    end
  end

  // control register; master reset brings the fields back to defaults
  always @(posedge CLK) begin
    if (!RST_N) begin
      src_sel_q  <= `TREF_SRC_RST;
      loop_sel_q <= `TREF_LOOP_RST;
    end else if (mrst_req) begin
      src_sel_q  <= `TREF_SRC_RST;
      loop_sel_q <= `TREF_LOOP_RST;
    end else if (wr_ctrl & ~mrst_busy) begin
      src_sel_q  <= PWDATA[`TREF_SRC_MSB:`TREF_SRC_LSB];
      // per-port loop select, bit n for port n
      loop_sel_q <= PWDATA[`TREF_LOOP_MSB:`TREF_LOOP_LSB];
    end
  end

  // line rate is a port setting and survives the master reset
  always @(posedge CLK) begin
    if (!RST_N) begin
      line_rate_q <= `TREF_RATE_RST;
    end else if (wr_rate) begin
      // two bits per port, code 11 stored but reserved
      line_rate_q <= PWDATA[7:0];
    end
  end

  // self-clearing; a new request restarts the full pulse
  always @* begin
    mrst_count_d = mrst_count_q;
    if (mrst_req) begin
      mrst_count_d = `TREF_MRST_CYCLES;
    end else if (mrst_busy) begin
      mrst_count_d = mrst_count_q - 4'h1;
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      mrst_count_q <= 4'h0;
      mrst_out_q   <= 1'b0;
    end else begin
      mrst_count_q <= mrst_count_d;
      mrst_out_q   <= (mrst_count_d != 4'h0);
    end
  end

  // tx_timing_ref_in comes from a pin, so it is synchronised before use
  always @(posedge CLK) begin
    if (!RST_N) begin
      tx_timing_ref_in_meta_q <= 1'b0;
      tx_timing_ref_in_sync_q <= 1'b0;
      tx_timing_ref_in_prev_q <= 1'b0;
    end else begin
      tx_timing_ref_in_meta_q <= TX_TIMING_REF_IN;
      tx_timing_ref_in_sync_q <= tx_timing_ref_in_meta_q;
      tx_timing_ref_in_prev_q <= tx_timing_ref_in_sync_q;
    end
  end

  // no edge counts until the chain holds real pin samples, so a pin that
  // idles high gives no false marker after reset
  always @(posedge CLK) begin
    if (!RST_N) begin
      tx_timing_ref_in_fill_q <= 2'h0;
    end else if (tx_timing_ref_in_fill_q != `TREF_SYNC_FILL) begin
      tx_timing_ref_in_fill_q <= tx_timing_ref_in_fill_q + 2'h1;
    end
  end

  assign tx_timing_ref_in_rise = tx_timing_ref_in_sync_q & ~tx_timing_ref_in_prev_q & (tx_timing_ref_in_fill_q == `TREF_SYNC_FILL);

  // marker source per port
  always @* begin
    tx_marker_d = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (loop_sel_q[i]) begin
        // external reference ignored, received marker looped
        tx_marker_d[i] = PORT_RX_MARKER[i];
      end else begin
        // marker generated from the external reference
        tx_marker_d[i] = tx_timing_ref_in_rise;
      end
    end
  end

  // markers are one-cycle requests; none leave while reset is active
  always @(posedge CLK) begin
    if (block_clr) begin
      tx_marker_q <= 4'h0;
    end else begin
      tx_marker_q <= tx_marker_d;
    end
  end

  // width per port; an unlooped port keeps the plain single-cycle pulse
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      width_d[i] = `TREF_WIDTH_PLAIN;
      if (loop_sel_q[i]) begin
        // widen so the looped marker is caught at the line rate
        case (line_rate_q[2*i +: 2])
          `TREF_MULT_1X: width_d[i] = `TREF_WIDTH_1X;
          `TREF_MULT_2X: width_d[i] = `TREF_WIDTH_2X;
          `TREF_MULT_4X: width_d[i] = `TREF_WIDTH_4X;
          default:       width_d[i] = `TREF_WIDTH_4X;
        endcase
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : widen
      pulse_widen u_widen (
        .clk   (CLK),
        .clr   (block_clr),
        .trig  (PORT_RX_MARKER[g]),
        .width (width_d[g]),
        .pulse (widened[g])
      );
    end
  endgenerate

  // select switches between pulses
  // a switch in mid-pulse would cut a pulse or forge one
  always @(posedge CLK) begin
    if (block_clr) begin
      src_live_q <= `TREF_SRC_RST;
    end else if (~widened[src_live_q] & ~widened[src_sel_q]) begin
      src_live_q <= src_sel_q;
    end
  end

  // shared output follows the selected port
  always @(posedge CLK) begin
    if (block_clr) begin
      rx_ref_out_q <= 1'b0;
    end else begin
      rx_ref_out_q <= widened[src_live_q];
    end
  end

  assign PRDATA            = rdata_q;
  assign PREADY            = ready_q;
  assign PSLVERR           = slverr_q;
  assign RX_TIMING_REF_OUT = rx_ref_out_q;
  assign TX_MARKER_REQ     = tx_marker_q;
  assign LINE_RATE         = line_rate_q;
  assign MASTER_RESET      = mrst_out_q;

endmodule

// ===== dv/tref_chk.sv
// port-level assertion checker for the timing reference control
`timescale 1ns/1ps

module tref_chk (
  input logic        CLK,
  input logic        RST_N,
  input logic        PSEL,
  input logic        PENABLE,
  input logic        PWRITE,
  input logic [7:0]  PADDR,
  input logic [31:0] PWDATA,
  input logic [31:0] PRDATA,
  input logic        PREADY,
  input logic        PSLVERR,
  input logic [3:0]  PORT_RX_MARKER,
  input logic        RX_TIMING_REF_OUT,
  input logic [3:0]  TX_MARKER_REQ,
  input logic [7:0]  LINE_RATE,
  input logic        MASTER_RESET
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  wire wr_done = PSEL && PENABLE && PREADY && PWRITE;
  wire mapped  = PADDR == 8'h40 || PADDR == 8'h44 || PADDR == 8'h48;
  wire mrst_wr = wr_done && PADDR == 8'h40 && PWDATA[5];

  a_ready_setup:  assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  a_err_decode:   assert property (PREADY |-> PSLVERR == !mapped)
    else $error("error flag wrong for address");
  a_rdata_idle:   assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside access");
  a_ctrl_rsvd:    assert property (PREADY && !PWRITE && PADDR == 8'h40
    |-> PRDATA[5:4] == 2'h0)
    else $error("reset or reserved bit read back");
  a_rate_write:   assert property (wr_done && PADDR == 8'h44
    |=> LINE_RATE == $past(PWDATA[7:0]))
    else $error("line rate not written");
  a_mrst_len:     assert property ($rose(MASTER_RESET)
    |-> MASTER_RESET [*8] ##1 !MASTER_RESET)
    else $error("master reset length wrong");
  a_mrst_cause:   assert property ($rose(MASTER_RESET) |-> $past(mrst_wr))
    else $error("master reset without write");
  a_mrst_quiet:   assert property (MASTER_RESET
    |-> !RX_TIMING_REF_OUT && TX_MARKER_REQ == 4'h0)
    else $error("activity during master reset");
  a_ref_cause:    assert property ($rose(RX_TIMING_REF_OUT)
    |-> $past(PORT_RX_MARKER, 2) != 4'h0)
    else $error("reference pulse without marker");

  cover property (mrst_wr);
  cover property ($rose(RX_TIMING_REF_OUT));
  cover property (TX_MARKER_REQ != 4'h0);
endmodule

bind timing_reference_control tref_chk i_chk (
  .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PORT_RX_MARKER(PORT_RX_MARKER), .RX_TIMING_REF_OUT(RX_TIMING_REF_OUT),
  .TX_MARKER_REQ(TX_MARKER_REQ), .LINE_RATE(LINE_RATE), .MASTER_RESET(MASTER_RESET)
);

// ===== dv/tb_top.sv
// self-checking bench for the timing reference control
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end

module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        pin = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  mk = 4'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, ref_out, mrst;
  wire  [3:0]  req;
  wire  [7:0]  rate;
  logic [31:0] rd;
  logic        er;
  int          err_count = 0;
  int          n_checks = 0;
  int          cyc = 0;

  timing_reference_control i_dut (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PORT_RX_MARKER(mk), .TX_TIMING_REF_IN(pin), .RX_TIMING_REF_OUT(ref_out),
    .TX_MARKER_REQ(req), .LINE_RATE(rate), .MASTER_RESET(mrst)
  );

  always #2.5 clk = ~clk;

  task complete_run;
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // the wait ends on pready; if pready never rises, only the bench timeout ends it
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one marker on port p; collect requests and reference width
  task automatic marker(input int p, input logic [3:0] xreq, input logic [4:0] xw);
    logic [3:0] seen;
    logic [4:0] w;
    seen = 4'h0;
    w = 5'h00;
    @(posedge clk);
    mk <= 4'h1 << p;
    @(posedge clk);
    mk <= 4'h0;
    repeat (12) begin
      @(posedge clk);
      seen = seen | req;
      w = w + ref_out;
    end
    `CHK(seen, xreq)
    `CHK(w, xw)
  endtask

  task t_defaults;
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h44, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h4c, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b0, 8'h48, 32'h0);
    `CHK({er, rd}, 33'h0)
  endtask

  task t_fields;
    apb(1'b1, 8'h40, 32'hdf);
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'hcf)
  endtask

  task t_loop;
    apb(1'b1, 8'h40, 32'h01);
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, 8'h44, c);
      marker(0, 4'h1, 5'h2 << c);
    end
    apb(1'b1, 8'h44, 32'h3);
    marker(0, 4'h1, 5'h8);
    apb(1'b1, 8'h40, 32'h41);
    marker(1, 4'h0, 5'h1);
  endtask

  task t_ext;
    logic [3:0] seen;
    seen = 4'h0;
    @(posedge clk);
    pin <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      seen = seen | req;
    end
    pin <= 1'b0;
    `CHK(seen, 4'he)
    repeat (4) @(posedge clk);
  endtask

  task t_mrst;
    int n;
    n = 0;
    apb(1'b1, 8'h44, 32'h26);
    apb(1'b1, 8'h40, 32'h25);
    repeat (12) begin
      @(posedge clk);
      n += (mrst === 1'b1);
    end
    `CHK(n, 8)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h44, 32'h0);
    `CHK(rd, 32'h26)
    `CHK(rate, 8'h26)
    marker(0, 4'h0, 5'h1);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_fields();
    t_loop();
    t_ext();
    t_mrst();
    complete_run();
  end
endmodule
